/* File: rtl/receive_irq_ctrl.sv */
// Receive interrupt enable register, receive status flags and the
// combined receive interrupt, reached over AXI4-Lite.
// Assumes condition pulses are synchronous to aclk, one cycle each.
// Notes for integrators
// Enable keeps only writable bits;
// reserved bits are masked on write.
// Status flags are write-one-to-clear.
// A hardware set beats a clear.
// The interrupt is registered, so it
// lags a flag or enable change by a
// clock; a poll sees the flag first.
// Event status and event enable form
// a second, separate interrupt path.
// Pulses must be one clock wide, or a
// clear may be undone by a long one.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps

module receive_irq_ctrl (
   input  wire logic                    aclk,            // Register clock, 25 MHz
   input  wire logic                    aresetn,         // Synchronous reset, active low
   input  wire logic                    clk_en,          // Freezes all state when low
   input  wire rx_irq_pkg::rx_events_s  rx_events,       // Condition pulses
   input  wire logic [4:0]              rx_slot,         // Current receive slot number
   input  wire logic [31:0]             s_axi_awaddr,    // Write address
   input  wire logic                    s_axi_awvalid,   // Write address valid
   output logic                         s_axi_awready,   // Write address ready
   input  wire logic [31:0]             s_axi_wdata,     // Write data
   input  wire logic [3:0]              s_axi_wstrb,     // Write byte strobes
   input  wire logic                    s_axi_wvalid,    // Write data valid
   output logic                         s_axi_wready,    // Write data ready
   output logic [1:0]                   s_axi_bresp,     // Write response
   output logic                         s_axi_bvalid,    // Write response valid
   input  wire logic                    s_axi_bready,    // Write response ready
   input  wire logic [31:0]             s_axi_araddr,    // Read address
   input  wire logic                    s_axi_arvalid,   // Read address valid
   output logic                         s_axi_arready,   // Read address ready
   output logic [31:0]                  s_axi_rdata,     // Read data
   output logic [1:0]                   s_axi_rresp,     // Read response
   output logic                         s_axi_rvalid,    // Read data valid
   input  wire logic                    s_axi_rready,    // Read data ready
   output logic                         receive_interrupt, // Combined receive interrupt
   output logic                         event_irq        // Sticky event interrupt
);

   // Register state
   logic [31:0] receive_irq_enable_r;  // Enable register, reserved bits held zero
   logic [7:0]  flags_r;               // Status flags, bit 3 unused (slot field)
   logic [1:0]  evt_stat_r;            // Sticky: bit0 interrupt rose, bit1 error seen
   logic [1:0]  evt_en_r;              // Event interrupt enables
   logic        receive_interrupt_q_r;              // Previous interrupt level for edge detect

   // Write channel holding registers
   logic        aw_full_r;             // Address captured
   logic        w_full_r;              // Data captured
   logic [7:0]  aw_addr_r;             // Captured write address
   logic [31:0] w_data_r;              // Captured write data
   logic [3:0]  w_strb_r;              // Captured strobes
   logic        do_write;              // Both halves present, response free

   // Byte-enable expanded write mask
   logic [31:0] wmask;                 // Strobe expanded per bit

   // Interrupt terms
   logic [7:0]  enable_by_flag;        // Enables realigned to flag positions
   logic        receive_interrupt_comb;             // Combinational receive interrupt
   logic        err_sum;               // Error summary bit
   logic [7:0]  hw_set;                // Hardware set per flag bit
   logic [7:0]  sw_clr;                // Software clear per flag bit
   logic [31:0] status_word;           // Status read value

   // Readies fall while a half is held
   // or the response waits, so only
   // one write is ever under way.
   // Trade-off: no write pipelining;
   // a clock lost per write buys a
   // single-compare decode.

   // Accept address and data independently, one outstanding write
   assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_r && !s_axi_bvalid;
   assign do_write      = aw_full_r && w_full_r && !s_axi_bvalid;

   // Only the low address byte is kept;
   // the map fits in it, upper bits are
   // ignored and alias onto the map.

   // Capture write address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr[7:0];
         end else if (do_write) begin
            aw_full_r <= 1'b0;  // Freed once the write is applied
         end
      end
   end

   // Strobes travel with the data so a
   // partial write touches only the
   // lanes that were offered, except the event clear, which ignores strobes.

   // Capture write data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_full_r <= 1'b0;
         end
      end
   end

   // Mask is built from held strobes,
   // never from the live bus.

   // Expand byte strobes into a bit mask, one generate per lane
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{w_strb_r[b]}};
   end

   // Response rises on the edge that
   // applies the write, so the target
   // holds its new value by bvalid.
   // Holding registers free that edge.

   // Write response; unmapped or read-only targets answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rx_irq_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_r)
               rx_irq_pkg::ENABLE_OFS,
               rx_irq_pkg::STATUS_OFS,
               rx_irq_pkg::EVT_CLR_OFS,
               rx_irq_pkg::EVT_EN_OFS: s_axi_bresp <= rx_irq_pkg::RESP_OKAY;
               default:                s_axi_bresp <= rx_irq_pkg::RESP_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Reserved bits carry no storage in
   // effect; masking here saves a read
   // mux and keeps readback at zero.
   // Per-byte strobes are honoured.

   // Enable register; reserved bits masked so they never store
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_irq_enable_r <= rx_irq_pkg::ENABLE_RST;
      end else if (clk_en && do_write && aw_addr_r == rx_irq_pkg::ENABLE_OFS) begin
         receive_irq_enable_r <= (receive_irq_enable_r & ~(wmask & rx_irq_pkg::ENABLE_MASK))
                               | (w_data_r & wmask & rx_irq_pkg::ENABLE_MASK);
      end
   end

   // Condition pulses arrive as a struct
   // in their own order; this picks
   // each one onto its flag position.
   // Bit 3 is the slot field, no flag.

   // Hardware sets, mapped onto status flag positions
   always_comb begin
      hw_set = 8'h00;
      hw_set[rx_irq_pkg::ST_OVERRUN] = rx_events.overrun;
      hw_set[rx_irq_pkg::ST_SYNC]    = rx_events.unexp_sync;
      hw_set[rx_irq_pkg::ST_CLKFAIL] = rx_events.clock_fail;
      // Last slot only ever sets alongside a data ready
      hw_set[rx_irq_pkg::ST_LAST]    = rx_events.data_ready && rx_events.last_slot;
      hw_set[rx_irq_pkg::ST_DATA]    = rx_events.data_ready;
      hw_set[rx_irq_pkg::ST_FRAME]   = rx_events.frame_start;
      hw_set[rx_irq_pkg::ST_DMAERR]  = rx_events.dma_error;
   end

   // A zero written leaves a flag alone,
   // so software may clear one flag
   // without a read-modify-write.

   // Software clear is write-one-to-clear on the status word
   assign sw_clr = (do_write && aw_addr_r == rx_irq_pkg::STATUS_OFS)
                 ? (w_data_r[7:0] & wmask[7:0] & rx_irq_pkg::STATUS_W1C[7:0])
                 : 8'h00;

   // Set is ORed after the clear, so a
   // condition that lands on the clear
   // edge survives and re-raises the
   // interrupt; no event is lost to a clear.
   // Frozen with everything else while
   // the clock enable is low.

   // Status flags: set wins over a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_r <= rx_irq_pkg::FLAGS_RST;
      end else if (clk_en) begin
         flags_r <= (flags_r & ~sw_clr) | hw_set;
      end
   end

   // Derived from flags, so it cannot
   // disagree with them after a clear.

   // Summary error bit, never stored
   assign err_sum = flags_r[rx_irq_pkg::ST_OVERRUN] | flags_r[rx_irq_pkg::ST_SYNC]
                  | flags_r[rx_irq_pkg::ST_CLKFAIL] | flags_r[rx_irq_pkg::ST_DMAERR];

   // Enable and status orders differ:
   // frame start is bit 7 of enable but
   // bit 6 of status, error bit 3 vs 7.

   // Realign enable bits to the status layout, which differs in order
   always_comb begin
      enable_by_flag = 8'h00;
      enable_by_flag[rx_irq_pkg::ST_FRAME]   = receive_irq_enable_r[rx_irq_pkg::EN_FRAME];
      enable_by_flag[rx_irq_pkg::ST_DATA]    = receive_irq_enable_r[rx_irq_pkg::EN_DATA];
      enable_by_flag[rx_irq_pkg::ST_LAST]    = receive_irq_enable_r[rx_irq_pkg::EN_LAST];
      enable_by_flag[rx_irq_pkg::ST_DMAERR]  = receive_irq_enable_r[rx_irq_pkg::EN_DMAERR];
      enable_by_flag[rx_irq_pkg::ST_CLKFAIL] = receive_irq_enable_r[rx_irq_pkg::EN_CLKFAIL];
      enable_by_flag[rx_irq_pkg::ST_SYNC]    = receive_irq_enable_r[rx_irq_pkg::EN_SYNC];
      enable_by_flag[rx_irq_pkg::ST_OVERRUN] = receive_irq_enable_r[rx_irq_pkg::EN_OVERRUN];
   end

   // Enabling a flag already set raises
   // the line; this gating is not edge based.

   // Per-flag gating; a zero enable removes only its own term
   assign receive_interrupt_comb = |(flags_r & enable_by_flag);

   // Registered to give a glitch-free
   // level to the interrupt controller,
   // at the cost of one clock latency.
   // The delayed copy feeds edge detect.

   // Registered interrupt output, one cycle after the flag or enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_interrupt <= 1'b0;
         receive_interrupt_q_r          <= 1'b0;
      end else if (clk_en) begin
         receive_interrupt <= receive_interrupt_comb;
         receive_interrupt_q_r          <= receive_interrupt;
      end
   end

   // Bit 0 notes a new interrupt rise,
   // bit 1 any error condition; both
   // stay until written with a one.
   // A new event on the clear edge wins.

   // Sticky events: interrupt rising edge, and any error flag set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_stat_r <= rx_irq_pkg::EVT_RST;
      end else if (clk_en) begin
         logic [1:0] clr;
         logic [1:0] set;
         clr = (do_write && aw_addr_r == rx_irq_pkg::EVT_CLR_OFS) ? w_data_r[1:0] : 2'h0;
         set = {(|(hw_set & 8'h87)), (receive_interrupt && !receive_interrupt_q_r)};
         // New event in the clearing cycle is kept
         evt_stat_r <= (evt_stat_r & ~clr) | set;
      end
   end

   // Only byte lane 0 holds event
   // enables; other lanes are ignored.

   // Event enable register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_en_r <= rx_irq_pkg::EVT_RST;
      end else if (clk_en && do_write && aw_addr_r == rx_irq_pkg::EVT_EN_OFS && w_strb_r[0]) begin
         evt_en_r <= w_data_r[1:0];
      end
   end

   // Event line, level, from registers
   assign event_irq = |(evt_stat_r & evt_en_r);

   // Only the slot parity is shown;
   // upper slot bits are not mapped.
   // Summary bit sits above the flags.

   // Status read word, slot parity in its own bit
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[7:0] = flags_r;
      status_word[rx_irq_pkg::ST_SLOT] = rx_slot[0];  // Odd or even slot indicator
      status_word[rx_irq_pkg::ST_ERR_SUM] = err_sum;
   end

   // Read data is captured when the
   // address is taken and then held
   // until rready, even if flags move.
   // Unmapped reads answer SLVERR, 0.

   // Read channel: one read outstanding, data one cycle after address
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= rx_irq_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rx_irq_pkg::RESP_OKAY;
            case (s_axi_araddr[7:0])
               rx_irq_pkg::ENABLE_OFS:   s_axi_rdata <= receive_irq_enable_r;
               rx_irq_pkg::STATUS_OFS:   s_axi_rdata <= status_word;
               rx_irq_pkg::EVT_STAT_OFS: s_axi_rdata <= {30'h0000_0000, evt_stat_r};
               rx_irq_pkg::EVT_EN_OFS:   s_axi_rdata <= {30'h0000_0000, evt_en_r};
               rx_irq_pkg::EVT_CLR_OFS:  s_axi_rdata <= 32'h0000_0000;  // Write only
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= rx_irq_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // receive_irq_ctrl

/* File: rtl/rx_irq_pkg.sv */
// Package for the receive interrupt enable and combining block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package rx_irq_pkg;

   // Register byte offsets
   localparam logic [7:0] ENABLE_OFS    = 8'h7C;  // Receive interrupt enable
   localparam logic [7:0] STATUS_OFS    = 8'h80;  // Receive status flags
   localparam logic [7:0] EVT_STAT_OFS  = 8'h84;  // Sticky event status, read only
   localparam logic [7:0] EVT_CLR_OFS   = 8'h88;  // Event clear, write only
   localparam logic [7:0] EVT_EN_OFS    = 8'h8C;  // Event interrupt enable

   // Enable register bit positions
   localparam int EN_OVERRUN     = 0;
   localparam int EN_SYNC        = 1;
   localparam int EN_CLKFAIL     = 2;
   localparam int EN_DMAERR      = 3;
   localparam int EN_LAST        = 4;
   localparam int EN_DATA        = 5;
   localparam int EN_FRAME       = 7;

   // Status register bit positions
   localparam int ST_OVERRUN     = 0;
   localparam int ST_SYNC        = 1;
   localparam int ST_CLKFAIL     = 2;
   localparam int ST_SLOT        = 3;
   localparam int ST_LAST        = 4;
   localparam int ST_DATA        = 5;
   localparam int ST_FRAME       = 6;
   localparam int ST_DMAERR      = 7;
   localparam int ST_ERR_SUM     = 8;

   // Writable masks and reset values
   localparam logic [31:0] ENABLE_MASK  = 32'h0000_00BF;
   localparam logic [31:0] STATUS_W1C   = 32'h0000_00F7;
   localparam logic [31:0] ENABLE_RST   = 32'h0000_0000;
   localparam logic [7:0]  FLAGS_RST    = 8'h00;
   localparam logic [1:0]  EVT_RST      = 2'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Receive condition pulses from the serializer side
   typedef struct packed {
      logic frame_start;   // New frame sync seen
      logic data_ready;    // Word moved to receive buffer
      logic last_slot;     // Slot just received is last of frame
      logic dma_error;     // Too many reads in a slot
      logic clock_fail;    // Receive clock check failed
      logic unexp_sync;    // Frame sync arrived early
      logic overrun;       // Buffer overwritten
   } rx_events_s;

endpackage

/* File: tb/irq_sink.sv */
// Interrupt controller model: counts each new request on the line.
// Assumes a level request synchronous to aclk.
`timescale 1ns/100ps
module irq_sink (
   input  wire logic aclk,              // Clock
   input  wire logic aresetn,           // Reset, active low
   input  wire logic receive_interrupt, // Level request
   output int        rises              // Requests seen
);
   logic seen_r; // Line level one edge ago
   // Edge detect, since a level held high is one request only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen_r <= 1'b0;
         rises  <= 0;
      end else begin
         seen_r <= receive_interrupt;
         if (receive_interrupt && !seen_r) rises <= rises + 1;  // New request
      end
   end
endmodule // irq_sink

/* File: tb/receive_irq_chk.sv */
// Checker bound to the receive interrupt block ports.
// Assumes full-word register writes, one write and one read at a time.
`timescale 1ns/100ps
module receive_irq_chk (
   input wire logic                   aclk,              // Clock
   input wire logic                   aresetn,           // Reset, active low
   input wire logic                   clk_en,            // State advance enable
   input wire rx_irq_pkg::rx_events_s rx_events,         // Condition pulses
   input wire logic [31:0]            s_axi_awaddr,      // Write address
   input wire logic                   s_axi_awvalid,     // Write address valid
   input wire logic                   s_axi_awready,     // Write address ready
   input wire logic [31:0]            s_axi_wdata,       // Write data
   input wire logic                   s_axi_wvalid,      // Write data valid
   input wire logic                   s_axi_wready,      // Write data ready
   input wire logic                   s_axi_bvalid,      // Write response valid
   input wire logic                   s_axi_bready,      // Write response ready
   input wire logic [31:0]            s_axi_araddr,      // Read address
   input wire logic                   s_axi_arvalid,     // Read address valid
   input wire logic                   s_axi_arready,     // Read address ready
   input wire logic [31:0]            s_axi_rdata,       // Read data
   input wire logic [1:0]             s_axi_rresp,       // Read response
   input wire logic                   s_axi_rvalid,      // Read data valid
   input wire logic                   s_axi_rready,      // Read data ready
   input wire logic                   receive_interrupt  // Combined interrupt
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [31:0] aw_q;  // Last accepted write address
   logic [31:0] w_q;   // Last accepted write data
   logic [31:0] en_q;  // Shadow of the enable register
   logic [7:0]  ar_q;  // Offset of the read under way
   logic        bv_q;  // Response valid one edge ago
   logic [7:0]  ev8;   // Pulses in enable bit layout
   // Last slot only counts together with data ready
   assign ev8 = {rx_events.frame_start, 1'b0, rx_events.data_ready,
                 rx_events.data_ready & rx_events.last_slot, rx_events.dma_error,
                 rx_events.clock_fail, rx_events.unexp_sync, rx_events.overrun};
   // Shadow moves when the response shows, the same edge the interrupt follows
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= 32'h0;
         bv_q <= 1'b0;
      end else begin
         bv_q <= s_axi_bvalid;
         if (s_axi_bvalid && !bv_q && aw_q[7:0] == rx_irq_pkg::ENABLE_OFS) begin
            en_q <= w_q & rx_irq_pkg::ENABLE_MASK;
         end
      end
   end
   // Capture of accepted addresses and data
   always_ff @(posedge aclk) begin
      if (clk_en && s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (clk_en && s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
      if (clk_en && s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr[7:0];
   end
   a_irq_needs_en: assert property (receive_interrupt |-> en_q != 32'h0)
      else $error("interrupt high with every enable clear");
   a_event_raises: assert property (clk_en && |(ev8 & en_q[7:0]) |-> ##2 receive_interrupt)
      else $error("enabled condition did not raise interrupt");
   a_enable_read: assert property (s_axi_rvalid && ar_q == rx_irq_pkg::ENABLE_OFS
      |-> s_axi_rdata == en_q) else $error("enable readback wrong");
   a_err_summary: assert property (s_axi_rvalid && ar_q == rx_irq_pkg::STATUS_OFS
      |-> s_axi_rdata[8] == |{s_axi_rdata[7], s_axi_rdata[2:0]}) else $error("summary wrong");
   a_unmapped_err: assert property (s_axi_rvalid && !(ar_q inside {8'h7C, 8'h80, 8'h84,
      8'h88, 8'h8C}) |-> s_axi_rresp == rx_irq_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answering");
   c_irq_rise: cover property ($rose(receive_interrupt));
   c_read_err: cover property (s_axi_rvalid && s_axi_rresp == rx_irq_pkg::RESP_SLVERR);
   c_slow_read: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // receive_irq_chk
bind receive_irq_ctrl receive_irq_chk u_receive_irq_chk (.*);

/* File: tb/testbench.sv */
// Self-checking bench for the receive interrupt block.
// Assumes one host issuing one register cycle at a time.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch at %0t: got %h, expected %h", $time, got, exp); end end
module testbench;
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;  // Clock, reset, enable
   rx_irq_pkg::rx_events_s rx_events = '0;            // Condition pulses
   logic [4:0]  rx_slot = 5'h0;                       // Slot number
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;                   // Whole words only
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, receive_interrupt, event_irq;  // Design outputs
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;        // Responses
   logic [31:0] en_m, v, rd_v;                        // Model enable, scratch
   logic [7:0]  fl_m = 8'h0;                          // Model status flags
   int err_total = 0, n_checks = 0, rises, n0, k, j, b;
   receive_irq_ctrl u_receive_irq_ctrl (.aclk, .aresetn, .clk_en, .rx_events, .rx_slot,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .receive_interrupt, .event_irq);
   irq_sink u_irq_sink (.aclk, .aresetn, .receive_interrupt, .rises);
   always #20 aclk = ~aclk;  // 25 MHz
   // Write: both halves offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit ta, tw;
      ta = 0;
      tw = 0;
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin ta = 1; s_axi_awvalid <= 1'b0; end
         if (s_axi_wvalid && s_axi_wready) begin tw = 1; s_axi_wvalid <= 1'b0; end
      end while (!(ta && tw));
      repeat ($urandom_range(2)) @(posedge aclk);  // Slow host now and then
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Read with a random delay before accepting data
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat ($urandom_range(2)) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // One-cycle condition pulse, mirrored into the model flags
   task automatic pulse(input logic [6:0] e);
      @(posedge aclk);
      rx_events <= e;
      @(posedge aclk);
      rx_events <= '0;
      fl_m |= {e[3], e[6], e[5], e[5] & e[4], 1'b0, e[2], e[1], e[0]};
   endtask
   function automatic logic exp_irq();
      return |({fl_m[6], 1'b0, fl_m[5:4], fl_m[7], fl_m[2:0]} & en_m[7:0]);
   endfunction
   function automatic logic [31:0] exp_st();
      return {23'h0, |{fl_m[7], fl_m[2:0]}, fl_m[7:4], rx_slot[0], fl_m[2:0]};
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Watchdog well beyond the expected thousand or so cycles
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'hF2892FEA));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(rx_irq_pkg::ENABLE_OFS, rd_v, rsp);
      `CHK(rd_v, rx_irq_pkg::ENABLE_RST)
      $display("test reset done");
      // One-hot enables, one-hot holes, then random traffic
      for (k = 0; k < 30; k++) begin
         j = k % 7;
         b = (j == 6) ? 7 : j;
         rx_slot <= 5'($urandom);
         v = (k < 7) ? 32'h1 << b : (k < 14) ? ~(32'h1 << b) : $urandom;
         wr(rx_irq_pkg::ENABLE_OFS, v, rsp);
         en_m = v & rx_irq_pkg::ENABLE_MASK;
         rd(rx_irq_pkg::ENABLE_OFS, rd_v, rsp);
         `CHK(rd_v, en_m)
         v = (k < 14) ? (32'h1 << j) | ((j == 4) ? 32'h20 : 32'h0) : $urandom;
         pulse(v[6:0]);
         repeat (3) @(posedge aclk);
         `CHK(receive_interrupt, exp_irq())
         rd(rx_irq_pkg::STATUS_OFS, rd_v, rsp);
         `CHK(rd_v, exp_st())
         v = $urandom;
         wr(rx_irq_pkg::STATUS_OFS, v, rsp);
         fl_m &= ~v[7:0];
         repeat (3) @(posedge aclk);
         `CHK(receive_interrupt, exp_irq())
         wr(rx_irq_pkg::STATUS_OFS, 32'hFF, rsp);
         fl_m = 8'h0;
      end
      $display("test enables done");
      // Clear collides with a fresh DMA error; the flag must survive
      wr(rx_irq_pkg::EVT_EN_OFS, 32'h3, rsp);
      wr(rx_irq_pkg::EVT_CLR_OFS, 32'h3, rsp);
      wr(rx_irq_pkg::ENABLE_OFS, 32'h08, rsp);
      en_m = 32'h08;
      n0 = rises;
      fork
         wr(rx_irq_pkg::STATUS_OFS, 32'h80, rsp);
         begin
            repeat (2) @(posedge aclk);
            rx_events.dma_error <= 1'b1;
            repeat (2) @(posedge aclk);
            rx_events.dma_error <= 1'b0;
         end
      join
      fl_m = 8'h80;
      repeat (3) @(posedge aclk);
      `CHK(receive_interrupt, 1'b1)
      `CHK(rises, n0 + 1)
      rd(rx_irq_pkg::STATUS_OFS, rd_v, rsp);
      `CHK(rd_v, exp_st())
      `CHK(event_irq, 1'b1)
      rd(rx_irq_pkg::EVT_STAT_OFS, rd_v, rsp);
      `CHK(rd_v, 32'h3)
      wr(rx_irq_pkg::EVT_CLR_OFS, 32'h1, rsp);
      rd(rx_irq_pkg::EVT_STAT_OFS, rd_v, rsp);
      `CHK(rd_v, 32'h2)
      wr(rx_irq_pkg::EVT_EN_OFS, 32'h0, rsp);
      @(posedge aclk);
      `CHK(event_irq, 1'b0)
      wr(rx_irq_pkg::EVT_STAT_OFS, 32'h3, rsp);
      `CHK(rsp, rx_irq_pkg::RESP_SLVERR)
      rd(8'h40, rd_v, rsp);
      `CHK({rsp, rd_v}, {rx_irq_pkg::RESP_SLVERR, 32'h0})
      $display("test collision and events done");
      tally_and_finish();
   end
endmodule // testbench
